// [hdl/host_port_sync.sv]
// module: multi-bit two-flop synchroniser for asynchronous host strobes
`timescale 1ns/10ps
module host_port_sync #(
   parameter int             W       = 6,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         clk_sys_in,
   input  wire logic         rstn_in,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   ////////////////////////////////////////////////////////////////////////////
   // one independent flop pair per bit; the first stage feeds only the second
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         logic meta_reg;
         logic sync_reg;
         // reset to the pin's pull level so no false strobe after reset
         always_ff @(posedge clk_sys_in or negedge rstn_in) begin
            if (!rstn_in) begin
               meta_reg <= RST_VAL[i];
               sync_reg <= RST_VAL[i];
            end else begin
               meta_reg <= async_in[i];
               sync_reg <= meta_reg;
            end
         end
         assign sync_out[i] = sync_reg;
      end
   endgenerate

endmodule

// [hdl/local_cpu_bus_host_port.sv]
// module: host bus slave port with four selectable host bus modes
`timescale 1ns/10ps
module local_cpu_bus_host_port #(
   parameter logic [9:0] IO_BASE   = host_port_pkg::IO_BASE,
   parameter logic [9:0] IO_MASK   = host_port_pkg::IO_MASK,
   parameter logic [9:0] WIDE_BASE = host_port_pkg::WIDE_BASE,
   parameter logic [9:0] WIDE_MASK = host_port_pkg::WIDE_MASK
) (
   input  wire logic                    clk_sys_in,
   input  wire logic                    rstn_in,
   input  wire logic [1:0]              mode_sel_in,
   input  wire logic [9:0]              host_addr_in,
   input  wire logic [15:0]             host_data_bus_in,
   output logic      [15:0]             host_data_bus_out,
   output logic      [1:0]              host_data_bus_oe_out,
   input  wire logic                    chip_select_n_in,
   input  wire logic                    io_read_strobe_n_in,
   input  wire logic                    io_write_strobe_n_in,
   input  wire logic                    upper_byte_en_n_in,
   input  wire logic                    dma_cycle_marker_in,
   output logic                         service_request_out,
   output logic                         ready_n_out,
   output logic                         ready_n_oe_out,
   output logic                         wide_port_indicate_n_out,
   output logic                         wide_port_indicate_n_oe_out,
   input  wire logic                    service_needed_in,
   output host_port_pkg::core_req_t     core_req_out,
   output logic                         core_rd_out,
   output logic                         core_wr_out,
   input  wire logic                    core_ready_in,
   input  wire logic [15:0]             core_rdata_in
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   host_port_pkg::port_state_t state_reg;
   host_port_pkg::port_state_t state_next;
   host_port_pkg::pin_t        pin_raw;
   host_port_pkg::pin_t        pin_syn;
   host_port_pkg::mode_t       mode_pick;
   logic [15:0]                wdata_lanes;

   logic       is_ds;
   logic       is_isa;
   logic       is_pse;
   logic       in_range;
   logic       wide_range;
   logic       qualified;
   logic       access_syn;
   logic       read_syn;
   logic [1:0] lanes_syn;
   logic       read_raw;
   logic       handshake;
   logic       waiting;
   logic       qual_raw;

   ////////////////////////////////////////////////////////////////////////////
   // strobe synchronisation
   // gather the strobe pins; bit 0 of the address doubles as lower strobe
   always_comb begin
      pin_raw.cs_n  = chip_select_n_in;
      pin_raw.rd_n  = io_read_strobe_n_in;
      pin_raw.wr_n  = io_write_strobe_n_in;
      pin_raw.dma_cycle_marker   = dma_cycle_marker_in;
      pin_raw.bhe_n = upper_byte_en_n_in;
      pin_raw.lds_n = host_addr_in[0];
   end

   // trade-off: two flops cost two clocks on every cycle, but a strobe edge
   // that lands near the clock can no longer reach the sequencer as two
   // different values in one cycle
   // strobes come from a foreign clock; the sequencer acts only on settled copies
   host_port_sync #(
      .W       ($bits(host_port_pkg::pin_t)),
      .RST_VAL (host_port_pkg::PIN_IDLE)
   ) u_sync (
      .clk_sys_in (clk_sys_in),
      .rstn_in    (rstn_in),
      .async_in   (pin_raw),
      .sync_out   (pin_syn)
   );

   ////////////////////////////////////////////////////////////////////////////
   // mode decode
   // the code is read once only; a strap that moves later is ignored until
   // the next reset, so a mode switch never lands in the middle of a cycle
   // translate the static select code into a one-hot mode
   always_comb begin
      case (mode_sel_in)
         host_port_pkg::SEL_SEP: mode_pick = host_port_pkg::MODE_SEP;
         host_port_pkg::SEL_DS:  mode_pick = host_port_pkg::MODE_DS;
         host_port_pkg::SEL_PSE: mode_pick = host_port_pkg::MODE_PSE;
         default:                mode_pick = host_port_pkg::MODE_ISA;
      endcase
   end

   assign is_ds  = (state_reg.mode == host_port_pkg::MODE_DS);
   assign is_isa = (state_reg.mode == host_port_pkg::MODE_ISA);
   assign is_pse = (state_reg.mode == host_port_pkg::MODE_PSE);

   ////////////////////////////////////////////////////////////////////////////
   // address decode and cycle qualification
   // window and wide ports are parameters; the defaults give a 32-port
   // window at the bottom of the space with two 16-bit ports in it
   // bit 0 is a strobe in ds mode, so it takes no part in the decode there
   always_comb begin
      logic [9:0] a;
      a = host_addr_in;
      if (is_ds) begin
         a[0] = 1'h0;
      end
      in_range   = ((a & IO_MASK) == (IO_BASE & IO_MASK));
      wide_range = in_range && ((a & WIDE_MASK) == (WIDE_BASE & WIDE_MASK));
   end

   // dma marker blocks isa cycles; the same pin enables program-select cycles
   // the synchronised marker is used so it lines up with the strobes
   always_comb begin
      qualified = 1'h1;
      if (is_isa) begin
         qualified = !pin_syn.dma_cycle_marker;
      end else if (is_pse) begin
         qualified = pin_syn.dma_cycle_marker;
      end
   end

   // the wide flag follows raw pins, so its qualifier must too; a synced
   // marker would lag and let a dma address raise the flag for two clocks
   always_comb begin
      qual_raw = 1'h1;
      if (is_isa) begin
         qual_raw = !dma_cycle_marker_in;
      end else if (is_pse) begin
         qual_raw = dma_cycle_marker_in;
      end
   end

   // a host cycle is present on the synchronised strobes
   always_comb begin
      access_syn = 1'h0;
      read_syn   = 1'h0;
      lanes_syn  = 2'h0;
      if (state_reg.mode_ok && !pin_syn.cs_n && qualified && in_range) begin
         if (is_ds) begin
            // lower and upper data strobes pick the lanes
            lanes_syn  = {!pin_syn.bhe_n, !pin_syn.lds_n};
            access_syn = !pin_syn.bhe_n || !pin_syn.lds_n;
            read_syn   = pin_syn.wr_n;
         end else begin
            // low lane always, upper lane by the byte enable
            // read wins when both strobes are low
            lanes_syn  = {!pin_syn.bhe_n, 1'h1};
            access_syn = !pin_syn.rd_n || !pin_syn.wr_n;
            read_syn   = !pin_syn.rd_n;
         end
      end
   end

   // a lane the host leaves disabled brings no stale data into the core
   genvar lane;
   generate
      for (lane = 0; lane < host_port_pkg::LANES; lane = lane + 1) begin : g_lane
         assign wdata_lanes[lane*8 +: 8] = lanes_syn[lane] ?
                                           host_data_bus_in[lane*8 +: 8] : 8'h00;
      end
   endgenerate

   // in ds mode a read is direction high plus either lane strobe
   // raw read strobe, so the bus is let go without synchroniser delay
   always_comb begin
      if (is_ds) begin
         read_raw = !chip_select_n_in && io_write_strobe_n_in &&
                    (!upper_byte_en_n_in || !host_addr_in[0]);
      end else begin
         read_raw = !chip_select_n_in && !io_read_strobe_n_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // core handshake
   // pin-to-core timing, core answering at once:
   //   edges 1 and 2  strobes pass the synchroniser flops
   //   edge 3         request captured, sequencer to wait
   //   edge 4         core takes it; read data into the data flops
   //   after that     lanes driven until the raw read strobe drops
   // each stalled clock delays edge 4 by one and pulls the ready pin once more;
   // in ds mode the pin stays quiet while waiting and acknowledges in done
   // limitation: a host that drops its strobe before the answer still gets
   // the core access, since the request is already captured
   // a strobe held low gives exactly one core access
   // the host keeps its strobes high for at least one clock between cycles, or
   // the sequencer still sits in done and the new cycle merges with the old
   // the core takes a request in a cycle where both rd or wr and ready are high
   assign core_req_out = state_reg.req;
   assign core_rd_out  = (state_reg.seq == host_port_pkg::ST_WAIT) && state_reg.req.read;
   assign core_wr_out  = (state_reg.seq == host_port_pkg::ST_WAIT) && !state_reg.req.read;
   assign handshake    = (state_reg.seq == host_port_pkg::ST_WAIT) && core_ready_in;
   assign waiting      = (state_reg.seq == host_port_pkg::ST_WAIT) && !core_ready_in;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      state_next = state_reg;
      // mode is caught once, in the first cycle after reset release
      if (!state_reg.mode_ok) begin
         state_next.mode    = mode_pick;
         state_next.mode_ok = 1'h1;
      end
      // 16-bit flag follows the presented, selected address; raw pins so the
      // host sees it early in its cycle, the synchronised path would be late
      state_next.wide = state_reg.mode_ok && !chip_select_n_in && qual_raw &&
                        wide_range;
      // service request polarity depends on the bus mode
      if (is_ds || is_pse) begin
         state_next.irq = !service_needed_in;
      end else begin
         state_next.irq = service_needed_in;
      end
      case (state_reg.seq)
         host_port_pkg::ST_IDLE: begin
            // the whole request is captured at once, so the core never sees a mix
            if (access_syn) begin
               state_next.seq        = host_port_pkg::ST_WAIT;
               state_next.req.addr   = host_addr_in;
               state_next.req.be     = lanes_syn;
               state_next.req.read   = read_syn;
               state_next.req.wdata  = wdata_lanes;
               if (is_ds) begin
                  state_next.req.addr[0] = 1'h0;
               end
            end
         end
         host_port_pkg::ST_WAIT: begin
            // read data is taken at the handshake edge, the only time it stands
            if (core_ready_in) begin
               state_next.seq = host_port_pkg::ST_DONE;
               if (state_reg.req.read) begin
                  state_next.rdata = core_rdata_in;
               end
            end
         end
         host_port_pkg::ST_DONE: begin
            // hold until the host ends the cycle; one access per strobe
            if (!access_syn) begin
               state_next.seq = host_port_pkg::ST_IDLE;
            end
         end
         // an illegal code from an upset returns to idle
         default: begin
            state_next.seq = host_port_pkg::ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   // reset puts the sequencer idle and forgets the mode, so a new strap
   // is taken after every reset
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_reg.seq       <= host_port_pkg::ST_IDLE;
         state_reg.mode      <= host_port_pkg::MODE_ISA;
         state_reg.mode_ok   <= 1'h0;
         state_reg.req       <= '0;
         state_reg.rdata     <= 16'h0000;
         state_reg.wide      <= 1'h0;
         state_reg.irq       <= 1'h0;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drivers
   // read data from flops; lanes driven only while the read is still on
   // hazard: the enable falls with the raw strobe, not the synchronised one,
   // so the bus is free before the host can turn it around
   always_comb begin
      host_data_bus_out    = state_reg.rdata;
      host_data_bus_oe_out = 2'h0;
      if ((state_reg.seq == host_port_pkg::ST_DONE) && state_reg.req.read && read_raw) begin
         host_data_bus_oe_out = state_reg.req.be;
      end
   end

   // open drain: pin level is always low, the enable decides
   // the pull-up outside makes the released level; driving high here would
   // fight other open-drain devices that share the ready line
   assign ready_n_out = 1'h0;

   // wait state while the core stalls, or acknowledge once data is taken
   always_comb begin
      if (is_ds) begin
         ready_n_oe_out = (state_reg.seq == host_port_pkg::ST_DONE) && access_syn;
      end else begin
         ready_n_oe_out = waiting;
      end
   end

   // second open-drain pin: again only the enable moves
   assign wide_port_indicate_n_out    = 1'h0;
   assign wide_port_indicate_n_oe_out = state_reg.wide;
   assign service_request_out         = state_reg.irq;

endmodule

// [shared/host_port_pkg.sv]
// package: constants, types and carriers of the local cpu bus host port
package host_port_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int ADDR_W = 10;
   localparam int DATA_W = 16;
   localparam int LANES  = 2;

   // static mode select codes on mode_sel_in
   localparam logic [1:0] SEL_ISA = 2'h0;
   localparam logic [1:0] SEL_SEP = 2'h1;
   localparam logic [1:0] SEL_DS  = 2'h2;
   localparam logic [1:0] SEL_PSE = 2'h3;

   // default address decode: port window and 16-bit capable ports
   localparam logic [ADDR_W-1:0] IO_BASE   = 10'h000;
   localparam logic [ADDR_W-1:0] IO_MASK   = 10'h3e0;
   localparam logic [ADDR_W-1:0] WIDE_BASE = 10'h010;
   localparam logic [ADDR_W-1:0] WIDE_MASK = 10'h3fe;

   // synchroniser depth
   localparam int SYNC_STAGES = 2;

   ////////////////////////////////////////////////////////////////////////////
   // bus modes, one-hot
   typedef enum logic [3:0] {
      MODE_ISA = 4'b0001,
      MODE_SEP = 4'b0010,
      MODE_DS  = 4'b0100,
      MODE_PSE = 4'b1000
   } mode_t;

   // access sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_DONE = 3'b100
   } seq_t;

   // host strobe pins that pass through the synchroniser
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic dma_cycle_marker;
      logic bhe_n;
      logic lds_n;
   } pin_t;

   // pin pull levels, used as synchroniser reset value
   localparam pin_t PIN_IDLE = '{cs_n: 1'h1, rd_n: 1'h1, wr_n: 1'h1,
                                 dma_cycle_marker: 1'h0, bhe_n: 1'h1, lds_n: 1'h1};

   // request handed to the core register file
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0]  be;
      logic [DATA_W-1:0] wdata;
      logic              read;
   } core_req_t;

   // whole state of the host port
   typedef struct packed {
      seq_t              seq;
      mode_t             mode;
      logic              mode_ok;
      core_req_t         req;
      logic [DATA_W-1:0] rdata;
      logic              wide;
      logic              irq;
   } port_state_t;

endpackage

// [test/host_bus_model.sv]
// host bus master model issuing i/o cycles on the port pins
`timescale 1ns/10ps
module host_bus_model (
   input  wire logic        clk_in,
   input  wire logic        ready_oe_in,
   input  wire logic [15:0] bus_in,
   output logic      [9:0]  addr_out,
   output logic             cs_n_out,
   output logic             rd_n_out,
   output logic             wr_n_out,
   output logic             bhe_n_out,
   output logic             aen_out,
   output logic             drv_out,
   output logic      [15:0] dat_out
);
   // idle pins at their pull levels
   initial begin
      addr_out = 10'h001;
      cs_n_out = 1'b1;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      bhe_n_out = 1'b1;
      aen_out = 1'b0;
      drv_out = 1'b0;
      dat_out = 16'h0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one cycle: hold everything until ready/ack allows, then release together
   task automatic xfer(input logic wr, ds, up, mk, input logic [9:0] a,
                       input logic [15:0] d, output logic [15:0] q, output logic k);
      int n;
      n = 0;
      @(posedge clk_in);
      #1 addr_out = a;
      cs_n_out = 1'b0;
      bhe_n_out = !up;
      aen_out = mk;
      if (ds) wr_n_out = !wr;
      else if (wr) wr_n_out = 1'b0;
      else rd_n_out = 1'b0;
      drv_out = wr;
      dat_out = d;
      repeat (5) @(posedge clk_in);
      // strobes pass a synchroniser, so the answer is never immediate
      while ((ds ? !ready_oe_in : ready_oe_in) && n < 40) begin
         @(posedge clk_in);
         n++;
      end
      k = ready_oe_in;
      @(posedge clk_in);
      #1 q = bus_in;
      cs_n_out = 1'b1;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      bhe_n_out = 1'b1;
      addr_out[0] = 1'b1;
      aen_out = 1'b0;
      drv_out = 1'b0;
      repeat (4) @(posedge clk_in);
   endtask
endmodule

// [test/host_port_properties.sv]
// checker: port-level properties of the host bus port
`timescale 1ns/10ps
module host_port_properties #(
   parameter logic [9:0] WIDE_BASE = host_port_pkg::WIDE_BASE,
   parameter logic [9:0] WIDE_MASK = host_port_pkg::WIDE_MASK
) (
   input  wire logic                     clk_sys_in,
   input  wire logic                     rstn_in,
   input  wire logic [1:0]               mode_sel_in,
   input  wire logic [9:0]               host_addr_in,
   input  wire logic                     chip_select_n_in,
   input  wire logic                     io_read_strobe_n_in,
   input  wire logic                     dma_cycle_marker_in,
   input  wire logic                     service_needed_in,
   input  wire logic                     service_request_out,
   input  wire logic                     ready_n_oe_out,
   input  wire logic                     wide_port_indicate_n_oe_out,
   input  wire logic [1:0]               host_data_bus_oe_out,
   input  wire host_port_pkg::core_req_t core_req_out,
   input  wire logic                     core_rd_out,
   input  wire logic                     core_wr_out,
   input  wire logic                     core_ready_in
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   ////////////////////////////////////////////////////////////////////////////
   // a core access is live; ds changes what the ready pin means
   wire logic act = core_rd_out || core_wr_out;
   wire logic ds  = mode_sel_in == host_port_pkg::SEL_DS;
   bus_release_a: assert property (!ds && io_read_strobe_n_in |-> host_data_bus_oe_out == 2'h0)
      else $error("data bus driven without read");
   req_hold_a: assert property (act && !core_ready_in |=> act && $stable(core_req_out))
      else $error("request moved while stalled");
   wait_state_a: assert property (!ds && act && !core_ready_in |-> ready_n_oe_out)
      else $error("no wait state while core busy");
   ds_ack_a: assert property (ds && act |-> !ready_n_oe_out)
      else $error("acknowledge before data accepted");
   cs_gate_a: assert property ($rose(act) |-> !($past(chip_select_n_in, 2)
      && $past(chip_select_n_in, 3) && $past(chip_select_n_in, 4)))
      else $error("access without chip select");
   isa_dma_a: assert property ($rose(act) && mode_sel_in == host_port_pkg::SEL_ISA
      |-> !($past(dma_cycle_marker_in, 2) && $past(dma_cycle_marker_in, 3)))
      else $error("access during dma cycle");
   pse_gate_a: assert property ($rose(act) && mode_sel_in == host_port_pkg::SEL_PSE
      |-> $past(dma_cycle_marker_in, 2) || $past(dma_cycle_marker_in, 3))
      else $error("access during program fetch");
   wide_flag_a: assert property (wide_port_indicate_n_oe_out |->
      !$past(chip_select_n_in) && ($past(host_addr_in) & WIDE_MASK) == (WIDE_BASE & WIDE_MASK)
      && !(mode_sel_in == host_port_pkg::SEL_ISA && $past(dma_cycle_marker_in)))
      else $error("wide flag outside wide ports");
   irq_pol_a: assert property ($past(rstn_in, 3) |-> service_request_out ==
      ($past(service_needed_in) ^ (mode_sel_in >= host_port_pkg::SEL_DS)))
      else $error("service request level wrong");
endmodule
bind local_cpu_bus_host_port host_port_properties #(.WIDE_BASE(WIDE_BASE),
   .WIDE_MASK(WIDE_MASK)) chk_u (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
   .mode_sel_in(mode_sel_in), .host_addr_in(host_addr_in),
   .chip_select_n_in(chip_select_n_in), .io_read_strobe_n_in(io_read_strobe_n_in),
   .dma_cycle_marker_in(dma_cycle_marker_in), .service_needed_in(service_needed_in),
   .service_request_out(service_request_out), .ready_n_oe_out(ready_n_oe_out),
   .wide_port_indicate_n_oe_out(wide_port_indicate_n_oe_out),
   .host_data_bus_oe_out(host_data_bus_oe_out), .core_req_out(core_req_out),
   .core_rd_out(core_rd_out), .core_wr_out(core_wr_out), .core_ready_in(core_ready_in));

// [test/local_cpu_bus_host_port_tb_top.sv]
// testbench: directed host cycles in all four bus modes
`timescale 1ns/10ps
module local_cpu_bus_host_port_tb_top;
   logic                     clk_sys_in = 1'b0;
   logic                     rstn_in = 1'b0;
   logic [1:0]               msel = 2'h0;
   logic                     need = 1'b0;
   logic [9:0]               addr;
   logic                     cs_n, rd_n, wr_n, bhe_n, dma_cycle_marker, drv, irq, rdy, wide, crd, cwr;
   logic [15:0]              hdat, dout;
   logic                     rdy_lvl, wide_lvl;
   wire logic [15:0]         bus;
   logic [1:0]               oe;
   host_port_pkg::core_req_t req, wlog;
   int                       stall = 0, cnt = 0, cyc = 0, n_fail = 0, n_checks = 0;
   logic                     act_seen = 1'b0, wide_seen = 1'b0;
   always #5 clk_sys_in = ~clk_sys_in;
   // released lanes fall to the pull-down level
   assign bus[7:0] = oe[0] ? dout[7:0] : (drv ? hdat[7:0] : 8'h00);
   assign bus[15:8] = oe[1] ? dout[15:8] : (drv ? hdat[15:8] : 8'h00);
   wire logic crdy = (crd || cwr) && cnt >= stall;
   host_bus_model host_u (.clk_in(clk_sys_in), .ready_oe_in(rdy), .bus_in(bus),
      .addr_out(addr), .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
      .bhe_n_out(bhe_n), .aen_out(dma_cycle_marker), .drv_out(drv), .dat_out(hdat));
   local_cpu_bus_host_port dut_u (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
      .mode_sel_in(msel), .host_addr_in(addr), .host_data_bus_in(bus),
      .host_data_bus_out(dout), .host_data_bus_oe_out(oe), .chip_select_n_in(cs_n),
      .io_read_strobe_n_in(rd_n), .io_write_strobe_n_in(wr_n),
      .upper_byte_en_n_in(bhe_n), .dma_cycle_marker_in(dma_cycle_marker), .service_request_out(irq),
      .ready_n_out(rdy_lvl), .ready_n_oe_out(rdy), .wide_port_indicate_n_out(wide_lvl),
      .wide_port_indicate_n_oe_out(wide), .service_needed_in(need), .core_req_out(req),
      .core_rd_out(crd), .core_wr_out(cwr), .core_ready_in(crdy),
      .core_rdata_in({6'h2a, req.addr}));
   ////////////////////////////////////////////////////////////////////////////
   // core stand-in with a settable stall, plus activity monitors and timeout
   always @(posedge clk_sys_in) begin
      cnt <= (crd || cwr) ? cnt + 1 : 0;
      if (cwr && crdy) wlog <= req;
      if (crd || cwr) act_seen <= 1'b1;
      if (wide) wide_seen <= 1'b1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, s);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic rst(input logic [1:0] m);
      #1 rstn_in = 1'b0;
      msel = m;
      repeat (8) @(posedge clk_sys_in);
      #1 rstn_in = 1'b1;
      act_seen = 1'b0;
      repeat (3) @(posedge clk_sys_in);
   endtask
   task automatic t_irq(input logic lo);
      #1 need = 1'b1;
      repeat (2) @(posedge clk_sys_in);
      #1 chk("irq on", !lo, irq);
      need = 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #1 chk("irq off", lo, irq);
   endtask
   task automatic t_isa();
      logic [15:0] q;
      logic k;
      rst(host_port_pkg::SEL_ISA);
      stall = 3;
      host_u.xfer(0, 0, 1, 0, 10'h005, 16'h0, q, k);
      chk("rd stall", {6'h2a, 10'h005}, q);
      chk("wait released", 1'b0, k);
      stall = 0;
      host_u.xfer(0, 0, 0, 0, 10'h00c, 16'h0, q, k);
      chk("rd low lane", 16'h000c, q);
      wide_seen = 1'b0;
      host_u.xfer(1, 0, 1, 0, 10'h011, 16'h3c5a, q, k);
      chk("wr data", 16'h3c5a, wlog.wdata);
      chk("wr addr", 10'h011, wlog.addr);
      chk("wr lanes", 2'h3, wlog.be);
      chk("wide on", 1'b1, wide_seen);
      chk("rdy level", 1'b0, rdy_lvl);
      chk("wide level", 1'b0, wide_lvl);
      act_seen = 1'b0;
      wide_seen = 1'b0;
      host_u.xfer(1, 0, 1, 1, 10'h010, 16'h1111, q, k);
      chk("dma ignored", 1'b0, act_seen);
      host_u.xfer(0, 0, 1, 0, 10'h025, 16'h0, q, k);
      chk("out of range", 1'b0, act_seen);
      chk("wide off", 1'b0, wide_seen);
      t_irq(1'b0);
      $display("test isa done");
   endtask
   task automatic t_ds();
      logic [15:0] q;
      logic k;
      rst(host_port_pkg::SEL_DS);
      stall = 2;
      host_u.xfer(1, 1, 0, 0, 10'h004, 16'h1234, q, k);
      chk("ds ack", 1'b1, k);
      chk("ds wr lanes", 2'h1, wlog.be);
      chk("ds wr data", 8'h34, wlog.wdata[7:0]);
      chk("ds wr upper", 8'h00, wlog.wdata[15:8]);
      host_u.xfer(0, 1, 1, 0, 10'h007, 16'h0, q, k);
      chk("ds rd upper", 16'ha800, q);
      t_irq(1'b1);
      $display("test ds done");
   endtask
   task automatic t_pse();
      logic [15:0] q;
      logic k;
      rst(host_port_pkg::SEL_PSE);
      host_u.xfer(1, 0, 1, 0, 10'h003, 16'h7777, q, k);
      chk("fetch ignored", 1'b0, act_seen);
      host_u.xfer(1, 0, 1, 1, 10'h003, 16'h5aa5, q, k);
      chk("pse wr", 16'h5aa5, wlog.wdata);
      t_irq(1'b1);
      $display("test pse done");
   endtask
   task automatic t_sep();
      logic [15:0] q;
      logic k;
      rst(host_port_pkg::SEL_SEP);
      stall = 0;
      host_u.xfer(0, 0, 1, 0, 10'h01f, 16'h0, q, k);
      chk("sep rd", {6'h2a, 10'h01f}, q);
      t_irq(1'b0);
      $display("test sep done");
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      t_isa();
      t_ds();
      t_pse();
      t_sep();
      test_done();
   end
endmodule
